// *** hw/pfs_pkg.sv ***
// constants for the port 7 / port 9 function select block
package pfs_pkg;
    localparam int PFS_P7_W = 12;
    localparam int PFS_P9_W = 10;
    localparam int PFS_PMC_W = 16;
    localparam int PFS_EXT_W = 8;
    localparam int PFS_SYNC_STAGES = 3;
    localparam logic [1:0] PFS_CODE_00 = 2'h0;
    localparam logic [1:0] PFS_CODE_01 = 2'h1;
    localparam logic [1:0] PFS_CODE_10 = 2'h2;
    localparam logic [1:0] PFS_CODE_11 = 2'h3;
    localparam logic PFS_IN_IDLE = 1'b1;
    localparam logic [15:0] PFS_PMC_ALL_ADDR = 16'hFFFF;
    localparam logic [11:0] PFS_P7_RESET = 12'h000;
    localparam logic [9:0] PFS_P9_RESET = 10'h000;
endpackage

// *** hw/pfs_pin_sync.sv ***
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pfs_pin_sync #(
    parameter int W = 10
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_out
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] level_nxt;

    // a change is accepted once stages two and three agree
    always_comb begin
        level_nxt = (s3_r & ~(s2_r ^ s3_r)) | (level_out & (s2_r ^ s3_r));
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            level_out <= '0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            level_out <= level_nxt;
        end
    end
endmodule
`default_nettype wire

// *** hw/pfs_port_mux.sv ***
// port 7 / port 9 pin function multiplexer
`timescale 1ns/1ps
`default_nettype none
// How it works
// - pin 0 in alternate mode gives address 0, key return 6, uart transmit or i2c data by code, any output open drain when its bit is set.
// - pin 1 in alternate mode gives address 1, key return 7, uart receive with key return 7, or i2c clock.
// - pin 2 gives address 2, timer 4 channel 1 input or timer 4 channel 1 output.
// - pin 3 gives address 3, timer 4 channel 0 input or timer 4 channel 0 output.
// - pin 4 gives address 4, timer 3 channel 1 input or timer 3 channel 1 output.
// - pin 5 gives address 5, timer 3 channel 0 input or timer 3 channel 0 output.
// - pin 6 gives address 6, timer 2 channel 1 input on code 10 or output on code 11.
// - pin 7 gives address 7, serial data in, timer 2 channel 0 input or output.
// - pin 8 has no extension bit and gives address 8 or serial data out.
// - pin 9 has no extension bit and gives address 9 or the two-way serial clock.
// - in alternate mode the function, and on pins 0 and 1 the open-drain bit, sets direction and drive, latch and direction ignored.
module pfs_port_mux
    import pfs_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [PFS_P7_W-1:0] port7_latch_in,
    input wire logic [PFS_P7_W-1:0] port7_dir_in,
    input wire logic [PFS_P9_W-1:0] port9_latch_in,
    input wire logic [PFS_P9_W-1:0] port9_dir_in,
    input wire logic [PFS_PMC_W-1:0] port9_mode_control_reg_in,
    input wire logic [PFS_EXT_W-1:0] port9_func_ext_in,
    input wire logic [PFS_P9_W-1:0] port9_func_in,
    input wire logic [1:0] port9_open_drain_reg_in,
    input wire logic [PFS_P7_W-1:0] port7_pin_in,
    input wire logic [PFS_P9_W-1:0] port9_pin_in,
    input wire logic [PFS_P9_W-1:0] addr_out_in,
    input wire logic uart_ch1_transmit_in,
    input wire logic i2c_ch2_data_in,
    input wire logic i2c_ch2_clock_in,
    input wire logic timer_grp4_ch1_output_in,
    input wire logic timer_grp4_ch0_output_in,
    input wire logic timer_grp3_ch1_output_in,
    input wire logic timer_grp3_ch0_output_in,
    input wire logic timer_grp2_ch1_output_in,
    input wire logic timer_grp2_ch0_output_in,
    input wire logic csi_ch1_serial_out_in,
    input wire logic csi_ch1_serial_clock_in,
    input wire logic csi_ch1_clock_drive_in,
    output logic [PFS_P7_W-1:0] port7_pin_out,
    output logic [PFS_P7_W-1:0] port7_pin_oe_out,
    output logic [PFS_P7_W-1:0] analog_in_sel_out,
    output logic [PFS_P7_W-1:0] port7_level_out,
    output logic [PFS_P9_W-1:0] port9_pin_out,
    output logic [PFS_P9_W-1:0] port9_pin_oe_out,
    output logic [PFS_P9_W-1:0] port9_level_out,
    output logic key_return_in6_out,
    output logic key_return_in7_out,
    output logic uart_ch1_receive_out,
    output logic i2c_ch2_data_out,
    output logic i2c_ch2_clock_out,
    output logic timer_grp4_ch1_input_out,
    output logic timer_grp4_ch0_input_out,
    output logic timer_grp3_ch1_input_out,
    output logic timer_grp3_ch0_input_out,
    output logic timer_grp2_ch1_input_out,
    output logic timer_grp2_ch0_input_out,
    output logic csi_ch1_serial_in_out,
    output logic csi_ch1_serial_clock_out
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [PFS_P7_W-1:0] p7_s;
    logic [PFS_P9_W-1:0] p9_s;

    pfs_pin_sync #(.W(PFS_P7_W)) u_sync7 (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .pin_in(port7_pin_in),
        .level_out(p7_s)
    );

    pfs_pin_sync #(.W(PFS_P9_W)) u_sync9 (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .pin_in(port9_pin_in),
        .level_out(p9_s)
    );

    // ------------------------------------------------------------
    // selection logic
    // ------------------------------------------------------------
    // {oe, out} for a pin that may be open drain
    function automatic logic [1:0] pfs_drive(input logic en, input logic v, input logic od);
        return {en & (~od | ~v), v & ~od};
    endfunction

    // extension and function bits as one code
    function automatic logic [1:0] pfs_code(input logic [PFS_EXT_W-1:0] e, input logic [PFS_P9_W-1:0] f,
                                            input int i);
        return {e[i], f[i]};
    endfunction

    logic [PFS_P9_W-1:0] mc;
    logic [PFS_P9_W-1:0] p9_out_nxt;
    logic [PFS_P9_W-1:0] p9_oe_nxt;
    logic [12:0] pin_in_nxt;
    logic [12:0] pin_in_r;
    logic [1:0] d0;
    logic [1:0] d1;

    assign mc = port9_mode_control_reg_in[PFS_P9_W-1:0];

    always_comb begin
        pin_in_nxt = {13{PFS_IN_IDLE}};
        // plain port behaviour
        p9_out_nxt = port9_latch_in;
        p9_oe_nxt = ~port9_dir_in;
        d0 = pfs_drive(~port9_dir_in[0], port9_latch_in[0], port9_open_drain_reg_in[0]);
        d1 = pfs_drive(~port9_dir_in[1], port9_latch_in[1], port9_open_drain_reg_in[1]);
        // alternate pins start undriven; latch and direction take no part
        for (int i = 0; i < PFS_P9_W; i++) begin
            if (mc[i]) begin
                p9_out_nxt[i] = 1'b0;
                p9_oe_nxt[i] = 1'b0;
            end
        end
        if (mc[0]) begin
            unique case (pfs_code(port9_func_ext_in, port9_func_in, 0))
                PFS_CODE_00: d0 = pfs_drive(1'b1, addr_out_in[0], port9_open_drain_reg_in[0]);
                PFS_CODE_01: begin
                    d0 = 2'h0;
                    pin_in_nxt[0] = p9_s[0];
                end
                PFS_CODE_10: d0 = pfs_drive(1'b1, uart_ch1_transmit_in, port9_open_drain_reg_in[0]);
                PFS_CODE_11: begin
                    d0 = pfs_drive(1'b1, i2c_ch2_data_in, port9_open_drain_reg_in[0]);
                    pin_in_nxt[3] = p9_s[0];
                end
            endcase
        end
        if (mc[1]) begin
            unique case (pfs_code(port9_func_ext_in, port9_func_in, 1))
                PFS_CODE_00: d1 = pfs_drive(1'b1, addr_out_in[1], port9_open_drain_reg_in[1]);
                PFS_CODE_01: begin
                    d1 = 2'h0;
                    pin_in_nxt[1] = p9_s[1];
                end
                PFS_CODE_10: begin
                    d1 = 2'h0;
                    pin_in_nxt[1] = p9_s[1];
                    pin_in_nxt[2] = p9_s[1];
                end
                PFS_CODE_11: begin
                    d1 = pfs_drive(1'b1, i2c_ch2_clock_in, port9_open_drain_reg_in[1]);
                    pin_in_nxt[4] = p9_s[1];
                end
            endcase
        end
        {p9_oe_nxt[0], p9_out_nxt[0]} = d0;
        {p9_oe_nxt[1], p9_out_nxt[1]} = d1;
        // pins 2 to 5: address, timer input, timer output, reserved
        for (int i = 2; i <= 5; i++) begin
            if (mc[i]) begin
                unique case (pfs_code(port9_func_ext_in, port9_func_in, i))
                    PFS_CODE_00: begin
                        p9_out_nxt[i] = addr_out_in[i];
                        p9_oe_nxt[i] = 1'b1;
                    end
                    PFS_CODE_01: pin_in_nxt[3 + i] = p9_s[i];
                    PFS_CODE_10: begin
                        p9_oe_nxt[i] = 1'b1;
                        p9_out_nxt[i] = (i == 2) ? timer_grp4_ch1_output_in :
                                        (i == 3) ? timer_grp4_ch0_output_in :
                                        (i == 4) ? timer_grp3_ch1_output_in : timer_grp3_ch0_output_in;
                    end
                    PFS_CODE_11: p9_oe_nxt[i] = 1'b0;
                endcase
            end
        end
        if (mc[6]) begin
            unique case (pfs_code(port9_func_ext_in, port9_func_in, 6))
                PFS_CODE_00: {p9_oe_nxt[6], p9_out_nxt[6]} = {1'b1, addr_out_in[6]};
                PFS_CODE_01: p9_oe_nxt[6] = 1'b0;
                PFS_CODE_10: pin_in_nxt[9] = p9_s[6];
                PFS_CODE_11: {p9_oe_nxt[6], p9_out_nxt[6]} = {1'b1, timer_grp2_ch1_output_in};
            endcase
        end
        if (mc[7]) begin
            unique case (pfs_code(port9_func_ext_in, port9_func_in, 7))
                PFS_CODE_00: {p9_oe_nxt[7], p9_out_nxt[7]} = {1'b1, addr_out_in[7]};
                PFS_CODE_01: pin_in_nxt[11] = p9_s[7];
                PFS_CODE_10: pin_in_nxt[10] = p9_s[7];
                PFS_CODE_11: {p9_oe_nxt[7], p9_out_nxt[7]} = {1'b1, timer_grp2_ch0_output_in};
            endcase
        end
        // pins 8 and 9 decode the function bit alone
        if (mc[8]) begin
            p9_oe_nxt[8] = 1'b1;
            p9_out_nxt[8] = port9_func_in[8] ? csi_ch1_serial_out_in : addr_out_in[8];
        end
        if (mc[9]) begin
            if (port9_func_in[9]) begin
                p9_oe_nxt[9] = csi_ch1_clock_drive_in;
                p9_out_nxt[9] = csi_ch1_serial_clock_in;
                pin_in_nxt[12] = p9_s[9];
            end else begin
                p9_oe_nxt[9] = 1'b1;
                p9_out_nxt[9] = addr_out_in[9];
            end
        end
    end

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            port7_pin_out <= PFS_P7_RESET;
            port7_pin_oe_out <= PFS_P7_RESET;
            analog_in_sel_out <= PFS_P7_RESET;
            port7_level_out <= PFS_P7_RESET;
            port9_pin_out <= PFS_P9_RESET;
            port9_pin_oe_out <= PFS_P9_RESET;
            port9_level_out <= PFS_P9_RESET;
            pin_in_r <= '1;
        end else begin
            port7_pin_out <= port7_latch_in;
            port7_pin_oe_out <= ~port7_dir_in;
            analog_in_sel_out <= port7_dir_in;
            port7_level_out <= p7_s;
            port9_pin_out <= p9_out_nxt;
            port9_pin_oe_out <= p9_oe_nxt;
            port9_level_out <= p9_s;
            pin_in_r <= pin_in_nxt;
        end
    end

    assign key_return_in6_out = pin_in_r[0];
    assign key_return_in7_out = pin_in_r[1];
    assign uart_ch1_receive_out = pin_in_r[2];
    assign i2c_ch2_data_out = pin_in_r[3];
    assign i2c_ch2_clock_out = pin_in_r[4];
    assign timer_grp4_ch1_input_out = pin_in_r[5];
    assign timer_grp4_ch0_input_out = pin_in_r[6];
    assign timer_grp3_ch1_input_out = pin_in_r[7];
    assign timer_grp3_ch0_input_out = pin_in_r[8];
    assign timer_grp2_ch1_input_out = pin_in_r[9];
    assign timer_grp2_ch0_input_out = pin_in_r[10];
    assign csi_ch1_serial_in_out = pin_in_r[11];
    assign csi_ch1_serial_clock_out = pin_in_r[12];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    sequence s_p7_read;
        mc[7] && port9_func_ext_in[7:7] == 1'b0 && port9_func_in[7];
    endsequence
    sequence s_p7_seen;
        csi_ch1_serial_in_out == $past(p9_s[7]) && !port9_pin_oe_out[7];
    endsequence

    a_pin0_addr_drive: assert property (mc[0] && !port9_func_ext_in[0] && !port9_func_in[0] &&
        !port9_open_drain_reg_in[0] |=> port9_pin_oe_out[0] && port9_pin_out[0] == $past(addr_out_in[0]))
        else $error("pin 0 address not driven");
    a_pin1_rx_key: assert property (mc[1] && port9_func_ext_in[1] && !port9_func_in[1] |=>
        uart_ch1_receive_out == key_return_in7_out && !port9_pin_oe_out[1])
        else $error("pin 1 receive and key return differ");
    a_pin2_timer_out: assert property (mc[2] && port9_func_ext_in[2] && !port9_func_in[2] |=>
        port9_pin_oe_out[2] && port9_pin_out[2] == $past(timer_grp4_ch1_output_in))
        else $error("pin 2 timer output wrong");
    a_pin3_timer_in: assert property (mc[3] && !port9_func_ext_in[3] && port9_func_in[3] |=>
        timer_grp4_ch0_input_out == $past(p9_s[3]) && !port9_pin_oe_out[3])
        else $error("pin 3 timer input wrong");
    a_pin4_addr: assert property (mc[4] && !port9_func_ext_in[4] && !port9_func_in[4] |=>
        port9_pin_out[4] == $past(addr_out_in[4]))
        else $error("pin 4 address wrong");
    a_pin5_timer_out: assert property (mc[5] && port9_func_ext_in[5] && !port9_func_in[5] |=>
        port9_pin_out[5] == $past(timer_grp3_ch0_output_in))
        else $error("pin 5 timer output wrong");
    a_pin6_timer_in: assert property (mc[6] && port9_func_ext_in[6] && !port9_func_in[6] |=>
        timer_grp2_ch1_input_out == $past(p9_s[6]) && !port9_pin_oe_out[6])
        else $error("pin 6 timer input wrong");
    a_pin7_serial_in: assert property (s_p7_read |=> s_p7_seen)
        else $error("pin 7 serial input wrong");
    a_pin8_serial_out: assert property (mc[8] && port9_func_in[8] |=>
        port9_pin_oe_out[8] && port9_pin_out[8] == $past(csi_ch1_serial_out_in))
        else $error("pin 8 serial output wrong");
    a_pin9_clock_dir: assert property (mc[9] && port9_func_in[9] |=>
        port9_pin_oe_out[9] == $past(csi_ch1_clock_drive_in))
        else $error("pin 9 clock direction wrong");
    a_alt_ignores_latch: assert property (mc[4] && port9_func_ext_in[4] && port9_func_in[4] |=>
        !port9_pin_oe_out[4] && !port9_pin_out[4])
        else $error("reserved code drives pin 4");
    a_port_mode_plain: assert property (!mc[5] |=>
        port9_pin_oe_out[5] == !$past(port9_dir_in[5]) && port9_pin_out[5] == $past(port9_latch_in[5]))
        else $error("plain port pin 5 wrong");
endmodule
`default_nettype wire

// *** sim/pfs_pin_partner.sv ***
// pin-side partner: resolves each pad from the block drive and the external drive
`timescale 1ns/1ps
`default_nettype none
module pfs_pin_partner #(
    parameter int W = 10
) (
    input wire logic [W-1:0] out_in,
    input wire logic [W-1:0] oe_in,
    input wire logic [W-1:0] ext_in,
    output logic [W-1:0] level_out
);
    // ----------------------------------------
    // pad resolution
    // ----------------------------------------
    // driven pads show the block value, released pads the external device value
    assign level_out = (oe_in & out_in) | (~oe_in & ext_in);
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// self-checking testbench for the port 7 / port 9 function select block
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import pfs_pkg::*;
;
    // ----------------------------------------
    // stimulus and observation
    // ----------------------------------------
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [11:0] p7_lat = '0, p7_dir = '0, p7_ext = '0, p7_lvl, p7_o, p7_oe, an_sel, p7_lv;
    logic [9:0] p9_lat = '0, p9_dir = '0, p9_fn = '0, adr = '0, p9_ext = '0, p9_lvl, p9_o, p9_oe, p9_lv;
    logic [15:0] mc = '0;
    logic [7:0] fx = '0;
    logic [1:0] od = '0;
    logic [11:0] per = '0;
    wire logic [12:0] pin_fn;
    logic [12:0] e_in;
    logic [9:0] e_o, e_oe, lv;
    int failures = 0;
    int n_tests = 0;
    // output source per pin and code: -1 none, 0 address, k+1 peripheral k
    localparam int OT [10][4] = '{'{0, -1, 1, 2}, '{0, -1, -1, 3}, '{0, -1, 4, -1}, '{0, -1, 5, -1},
        '{0, -1, 6, -1}, '{0, -1, 7, -1}, '{0, -1, -1, 8}, '{0, -1, -1, 9}, '{0, 10, -1, -1}, '{0, 11, -1, -1}};
    // peripheral input fed per pin and code, -1 none
    localparam int IT [10][4] = '{'{-1, 0, -1, 3}, '{-1, 1, 2, 4}, '{-1, 5, -1, -1}, '{-1, 6, -1, -1},
        '{-1, 7, -1, -1}, '{-1, 8, -1, -1}, '{-1, -1, 9, -1}, '{-1, 11, 10, -1}, '{-1, -1, -1, -1},
        '{-1, 12, -1, -1}};

    initial begin
        forever #25 ref_clk_in = ~ref_clk_in;
    end

    pfs_pin_partner #(.W(12)) p7_u (.out_in(p7_o), .oe_in(p7_oe), .ext_in(p7_ext), .level_out(p7_lvl));
    pfs_pin_partner #(.W(10)) p9_u (.out_in(p9_o), .oe_in(p9_oe), .ext_in(p9_ext), .level_out(p9_lvl));

    pfs_port_mux dut_u (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .port7_latch_in(p7_lat),
        .port7_dir_in(p7_dir), .port9_latch_in(p9_lat), .port9_dir_in(p9_dir),
        .port9_mode_control_reg_in(mc), .port9_func_ext_in(fx), .port9_func_in(p9_fn),
        .port9_open_drain_reg_in(od), .port7_pin_in(p7_lvl), .port9_pin_in(p9_lvl), .addr_out_in(adr),
        .uart_ch1_transmit_in(per[0]), .i2c_ch2_data_in(per[1]), .i2c_ch2_clock_in(per[2]),
        .timer_grp4_ch1_output_in(per[3]), .timer_grp4_ch0_output_in(per[4]),
        .timer_grp3_ch1_output_in(per[5]), .timer_grp3_ch0_output_in(per[6]),
        .timer_grp2_ch1_output_in(per[7]), .timer_grp2_ch0_output_in(per[8]),
        .csi_ch1_serial_out_in(per[9]), .csi_ch1_serial_clock_in(per[10]), .csi_ch1_clock_drive_in(per[11]),
        .port7_pin_out(p7_o), .port7_pin_oe_out(p7_oe), .analog_in_sel_out(an_sel), .port7_level_out(p7_lv),
        .port9_pin_out(p9_o), .port9_pin_oe_out(p9_oe), .port9_level_out(p9_lv),
        .key_return_in6_out(pin_fn[0]), .key_return_in7_out(pin_fn[1]), .uart_ch1_receive_out(pin_fn[2]),
        .i2c_ch2_data_out(pin_fn[3]), .i2c_ch2_clock_out(pin_fn[4]), .timer_grp4_ch1_input_out(pin_fn[5]),
        .timer_grp4_ch0_input_out(pin_fn[6]), .timer_grp3_ch1_input_out(pin_fn[7]),
        .timer_grp3_ch0_input_out(pin_fn[8]), .timer_grp2_ch1_input_out(pin_fn[9]),
        .timer_grp2_ch0_input_out(pin_fn[10]), .csi_ch1_serial_in_out(pin_fn[11]),
        .csi_ch1_serial_clock_out(pin_fn[12]));

    // ----------------------------------------
    // reference model and checks
    // ----------------------------------------
    task automatic model();
        logic [1:0] c;
        int s;
        logic v;
        for (int i = 0; i < 10; i++) begin
            c = {(i < 8) ? fx[i] : 1'b0, p9_fn[i]};
            s = OT[i][c];
            v = (s == 0) ? adr[i] : ((s > 0) ? per[s-1] : 1'b0);
            if (!mc[i]) begin
                e_o[i] = p9_lat[i];
                e_oe[i] = ~p9_dir[i];
            end else if (s < 0) begin
                e_o[i] = 1'b0;
                e_oe[i] = 1'b0;
            end else begin
                e_o[i] = v;
                e_oe[i] = (i == 9 && s > 0) ? per[11] : 1'b1;
            end
            // open drain on pins 0 and 1 drives low only, in every output use
            if (i < 2 && od[i]) begin
                e_oe[i] = e_oe[i] & ~e_o[i];
                e_o[i] = 1'b0;
            end
        end
        lv = (e_oe & e_o) | (~e_oe & p9_ext);
        e_in = '1;
        for (int i = 0; i < 10; i++) begin
            c = {(i < 8) ? fx[i] : 1'b0, p9_fn[i]};
            if (mc[i] && IT[i][c] >= 0) begin
                e_in[IT[i][c]] = lv[i];
            end
            if (mc[i] && i == 1 && c == 2'h2) begin
                e_in[1] = lv[1];
            end
        end
    endtask

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic vec(input bit d, input logic [1:0] c);
        logic [159:0] r;
        r = {$urandom, $urandom, $urandom, $urandom, $urandom};
        @(posedge ref_clk_in);
        p7_lat <= r[11:0];
        p7_dir <= r[23:12];
        p7_ext <= r[35:24];
        p9_lat <= r[45:36];
        p9_dir <= r[55:46];
        adr <= r[65:56];
        p9_ext <= r[75:66];
        od <= r[77:76];
        per <= r[89:78];
        if (d) begin
            mc <= PFS_PMC_ALL_ADDR;
            fx <= {8{c[1]}};
            p9_fn <= {10{c[0]}};
        end else begin
            mc <= r[105:90];
            fx <= r[113:106];
            p9_fn <= r[123:114];
        end
        @(posedge ref_clk_in);
        #1;
        model();
        chk("p9_out", 16'(p9_o), 16'(e_o));
        chk("p9_oe", 16'(p9_oe), 16'(e_oe));
        chk("p7_out", 16'(p7_o), 16'(p7_lat));
        chk("p7_oe", 16'(p7_oe), {4'h0, ~p7_dir});
        chk("analog_sel", 16'(an_sel), 16'(p7_dir));
        repeat (6) @(posedge ref_clk_in);
        #1;
        chk("p9_level", 16'(p9_lv), 16'(lv));
        chk("p7_level", 16'(p7_lv), 16'((~p7_dir & p7_lat) | (p7_dir & p7_ext)));
        chk("periph_in", 16'(pin_fn), 16'(e_in));
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------
    // sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (4000) @(posedge ref_clk_in);
        failures++;
        final_report();
    end

    initial begin
        void'($urandom(32'h3955));
        repeat (4) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        for (int c = 0; c < 4; c++) begin
            vec(1'b1, 2'(c));
        end
        repeat (300) vec(1'b0, 2'h0);
        @(posedge ref_clk_in);
        rst_in <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
        #1;
        chk("rst_oe", 16'(p9_oe), 16'h0000);
        chk("rst_periph", 16'(pin_fn), 16'h1fff);
        @(posedge ref_clk_in);
        rst_in <= 1'b0;
        repeat (20) vec(1'b0, 2'h0);
        final_report();
    end
endmodule
`default_nettype wire
